// >>> dtx_exec.sv
// execution unit for data-transfer, stack and i/o bit instructions
// assumes an issuing stage that holds i_start for one cycle while o_busy
// is low, and one-cycle latency data memory, flash and i/o reads
`timescale 1ns/1ps
`include "dtx_params.svh"
module dtx_exec import dtx_pkg::*; (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // instruction issue
  input wire logic i_start,
  input wire instr_t i_instr,
  // read data
  input wire logic [7:0] i_dmem_rdata,
  input wire logic [7:0] i_flash_rdata,
  input wire logic [7:0] i_io_rdata,
  // status
  output logic o_busy,
  output logic o_done,
  // data memory
  output mem_req_t o_dmem,
  // i/o space
  output mem_req_t o_io,
  // program flash
  output logic o_flash_re,
  output logic o_flash_we,
  output logic [15:0] o_flash_addr,
  output logic [15:0] o_flash_wdata,
  // stack pointer view
  output logic [15:0] o_sp
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_FETCH = 4'b0010,
    ST_EXEC = 4'b0100, ST_LAST = 4'b1000
  } state_t;
  state_t state;
  instr_t cur;
  logic [1:0] cyc;
  logic [15:0] ptr_y;
  logic [15:0] ptr_z;
  logic [15:0] sp;
  logic [7:0] src_a;
  logic [7:0] src_b;
  logic [7:0] rd_byte;
  logic rf_we;
  logic [4:0] rf_waddr;
  logic [7:0] rf_wdata;
  logic [4:0] raddr_a;
  logic [4:0] raddr_b;
  logic [15:0] z_next;
  logic [15:0] y_next;
  logic [15:0] sp_dec;
  logic [15:0] sp_inc;
  logic z_dec;
  logic [7:0] next_bits;
  logic [7:0] rf_r0;

  function automatic logic [1:0] op_cycles(input op_t op);
    case (op)
      OP_IN, OP_OUT: op_cycles = `DTX_CYC_ONE;
      OP_PLD_R0, OP_PLD, OP_PLD_INC: op_cycles = `DTX_CYC_THREE;
      default: op_cycles = `DTX_CYC_TWO;
    endcase
  endfunction

  function automatic logic [15:0] load_byte(input logic [15:0] p,
      input logic [4:0] lo, input logic we, input logic [4:0] a,
      input logic [7:0] d);
    load_byte = p;
    if (we && a == lo) begin
      load_byte[7:0] = d;
    end else if (we && a == lo + 5'h01) begin
      load_byte[15:8] = d;
    end
  endfunction

  // ----------------------------------------------------------------
  // register file and pointer steppers
  // ----------------------------------------------------------------
  // pointers are mirrored here; the file keeps the source operands
  assign raddr_a = i_start ? i_instr.reg_sel : cur.reg_sel;
  assign raddr_b = `DTX_REG_ONE;

  dtx_regfile u_regfile (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_we(rf_we),
    .i_waddr(rf_waddr),
    .i_wdata(rf_wdata),
    .i_raddr_a(raddr_a),
    .i_raddr_b(raddr_b),
    .o_rdata_a(src_a),
    .o_rdata_b(src_b)
  );

  assign z_dec = (cur.op == OP_ST_Z_DEC);

  dtx_ptr_step u_step_z (
    .i_ptr(ptr_z),
    .i_dec(z_dec),
    .o_ptr(z_next)
  );

  dtx_ptr_step u_step_y (
    .i_ptr(ptr_y),
    .i_dec(1'b0),
    .o_ptr(y_next)
  );

  dtx_ptr_step u_step_sp_dec (
    .i_ptr(sp),
    .i_dec(1'b1),
    .o_ptr(sp_dec)
  );

  dtx_ptr_step u_step_sp_inc (
    .i_ptr(sp),
    .i_dec(1'b0),
    .o_ptr(sp_inc)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_IDLE;
      cur <= '0;
      cyc <= 2'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            cur <= i_instr;
            cyc <= op_cycles(i_instr.op);
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state <= (cyc == `DTX_CYC_ONE) ? ST_LAST : ST_EXEC;
        end
        ST_EXEC: begin
          if (cyc == `DTX_CYC_THREE) begin
            cyc <= `DTX_CYC_TWO;
          end else begin
            state <= ST_LAST;
          end
        end
        ST_LAST: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // memory and i/o requests, registered from ST_FETCH, ST_EXEC or ST_LAST, and from ST_IDLE for port input
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_dmem <= '0;
      o_io <= '0;
      o_flash_re <= 1'b0;
      o_flash_we <= 1'b0;
      o_flash_addr <= 16'h0000;
      o_flash_wdata <= 16'h0000;
    end else begin
      o_dmem.we <= 1'b0;
      o_dmem.re <= 1'b0;
      o_io.we <= 1'b0;
      o_io.re <= 1'b0;
      o_flash_re <= 1'b0;
      o_flash_we <= 1'b0;
      if (state == ST_IDLE && i_start && i_instr.op == OP_IN) begin
        o_io.re <= 1'b1;
        o_io.addr <= {10'h000, i_instr.io_addr};
      end
      if (state == ST_FETCH) begin
        o_dmem.wdata <= src_a;
        o_io.wdata <= src_a;
        o_io.addr <= {10'h000, cur.io_addr};
        case (cur.op)
          OP_ST_DISP_Y: begin
            o_dmem.we <= 1'b1;
            o_dmem.addr <= ptr_y + {10'h000, cur.disp};
          end
          OP_ST_Z, OP_ST_Z_INC: begin
            o_dmem.we <= 1'b1;
            o_dmem.addr <= ptr_z;
          end
          OP_ST_Z_DEC: begin
            o_dmem.we <= 1'b1;
            o_dmem.addr <= z_next;
          end
          OP_ST_Y_INC: begin
            o_dmem.we <= 1'b1;
            o_dmem.addr <= ptr_y;
          end
          OP_ST_DIRECT: begin
            o_dmem.we <= 1'b1;
            o_dmem.addr <= cur.addr;
          end
          OP_PUSH: begin
            o_dmem.we <= 1'b1;
            o_dmem.addr <= sp;
          end
          OP_POP: begin
            o_dmem.re <= 1'b1;
            o_dmem.addr <= sp_inc;
          end
          OP_PWR: begin
            o_flash_we <= 1'b1;
            o_flash_addr <= ptr_z;
            o_flash_wdata <= {src_b, rf_r0};
          end
          OP_BSET, OP_BCLR: begin
            o_io.re <= 1'b1;
          end
          OP_OUT: begin
            o_io.we <= 1'b1;
          end
          default: begin
            o_dmem.we <= 1'b0;
          end
        endcase
      end else if (state == ST_EXEC && cyc == `DTX_CYC_THREE) begin
        o_flash_re <= 1'b1;
        o_flash_addr <= ptr_z;
      end else if (state == ST_LAST &&
                   (cur.op == OP_BSET || cur.op == OP_BCLR)) begin
        o_io.we <= 1'b1;
        o_io.wdata <= next_bits;
      end
    end
  end

  // ----------------------------------------------------------------
  // read-modify-write of a single i/o bit
  // ----------------------------------------------------------------
  logic [7:0] bit_mask;
  assign bit_mask = 8'h01 << cur.bit_sel;
  always_comb begin
    if (cur.op == OP_BSET) begin
      next_bits = i_io_rdata | bit_mask;
    end else begin
      next_bits = i_io_rdata & ~bit_mask;
    end
  end

  // register zero shadow for the program write pair
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rf_r0 <= 8'h00;
    end else if (rf_we && rf_waddr == `DTX_REG_ZERO) begin
      rf_r0 <= rf_wdata;
    end
  end

  // ----------------------------------------------------------------
  // result write-back; no status flag is ever touched
  // ----------------------------------------------------------------
  always_comb begin
    rf_we = 1'b0;
    rf_waddr = cur.reg_sel;
    rd_byte = i_flash_rdata;
    if (cur.op == OP_POP) begin
      rd_byte = i_dmem_rdata;
    end else if (cur.op == OP_IN) begin
      rd_byte = i_io_rdata;
    end
    rf_wdata = rd_byte;
    if (state == ST_LAST) begin
      case (cur.op)
        OP_PLD_R0: begin
          rf_we = 1'b1;
          rf_waddr = `DTX_REG_ZERO;
        end
        OP_PLD, OP_PLD_INC, OP_POP, OP_IN: begin
          rf_we = 1'b1;
        end
        default: begin
          rf_we = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pointer and stack pointer updates
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ptr_z <= 16'h0000;
      ptr_y <= 16'h0000;
    end else begin
      ptr_z <= load_byte(ptr_z, `DTX_PTR_Z_LO, rf_we, rf_waddr, rf_wdata);
      ptr_y <= load_byte(ptr_y, `DTX_PTR_Y_LO, rf_we, rf_waddr, rf_wdata);
      if (state == ST_LAST && (cur.op == OP_ST_Z_INC ||
          cur.op == OP_ST_Z_DEC || cur.op == OP_PLD_INC)) begin
        ptr_z <= z_next;
      end
      if (state == ST_LAST && cur.op == OP_ST_Y_INC) begin
        ptr_y <= y_next;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sp <= `DTX_SP_RESET;
    end else if (state == ST_LAST) begin
      if (cur.op == OP_PUSH) begin
        sp <= sp_dec;
      end else if (cur.op == OP_POP) begin
        sp <= sp_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_sp <= `DTX_SP_RESET;
    end else begin
      o_busy <= (state == ST_IDLE) ? i_start : (state != ST_LAST);
      o_done <= (state == ST_LAST);
      o_sp <= sp;
    end
  end
endmodule

// >>> dtx_params.svh
// constants of the data-transfer and i/o bit execution unit
// assumes inclusion by every module that reads one of its macros
// Operation
// - displaced store writes source to second pointer plus offset, two cycles
// - plain indirect store writes source to third pointer, two cycles
// - post-increment store writes then bumps third pointer, two cycles
// - pre-decrement store drops third pointer then writes, two cycles
// - direct store writes source to instruction address, two cycles
// - bare program load puts flash byte at third pointer in register zero
// - program load copies flash byte into chosen register over three cycles
// - post-increment program load copies byte then bumps third pointer
// - program write stores register one and zero pair at third pointer
// - port input copies i/o location into register in one cycle
// - port output writes source register to i/o location in one cycle
// - push writes source on stack, pop loads from stack, two cycles
// - pop returns top of stack byte into destination in two cycles
// - bit set forces chosen i/o bit to one in two cycles
// - bit clear forces chosen i/o bit to zero in two cycles
// - post-increment store via second pointer writes then bumps it
`ifndef DTX_PARAMS_SVH
`define DTX_PARAMS_SVH
`define DTX_CYC_ONE 2'h1
`define DTX_CYC_TWO 2'h2
`define DTX_CYC_THREE 2'h3
`define DTX_REG_ZERO 5'h00
`define DTX_REG_ONE 5'h01
`define DTX_PTR_Y_LO 5'h1c
`define DTX_PTR_Z_LO 5'h1e
`define DTX_SP_RESET 16'h0000
`define DTX_STEP 16'h0001
`endif

// >>> dtx_pkg.sv
// types of the data-transfer and i/o bit execution unit
// assumes dtx_params.svh sits in the same folder
package dtx_pkg;
  typedef enum logic [4:0] {
    OP_NONE = 5'h00, OP_ST_DISP_Y = 5'h01, OP_ST_Z = 5'h02,
    OP_ST_Z_INC = 5'h03, OP_ST_Z_DEC = 5'h04, OP_ST_DIRECT = 5'h05,
    OP_PLD_R0 = 5'h06, OP_PLD = 5'h07, OP_PLD_INC = 5'h08,
    OP_PWR = 5'h09, OP_IN = 5'h0a, OP_OUT = 5'h0b, OP_PUSH = 5'h0c,
    OP_POP = 5'h0d, OP_BSET = 5'h0e, OP_BCLR = 5'h0f,
    OP_ST_Y_INC = 5'h10
  } op_t;
  typedef struct packed {
    op_t op;
    logic [4:0] reg_sel;
    logic [5:0] io_addr;
    logic [2:0] bit_sel;
    logic [5:0] disp;
    logic [15:0] addr;
  } instr_t;
  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;
endpackage

// >>> dtx_regfile.sv
// working register file, 32 bytes, registered read ports
// assumes one clock and asynchronous active low reset
`timescale 1ns/1ps
module dtx_regfile (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // write port
  input wire logic i_we,
  input wire logic [4:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // read ports
  input wire logic [4:0] i_raddr_a,
  input wire logic [4:0] i_raddr_b,
  output logic [7:0] o_rdata_a,
  output logic [7:0] o_rdata_b
);
  logic [7:0] mem [0:31];

  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata_a <= 8'h00;
      o_rdata_b <= 8'h00;
    end else begin
      o_rdata_a <= mem[i_raddr_a];
      o_rdata_b <= mem[i_raddr_b];
    end
  end
endmodule

// >>> dtx_ptr_step.sv
// sixteen bit pointer stepper, wraps modulo 2^16
// assumes purely combinational use
`timescale 1ns/1ps
`include "dtx_params.svh"
module dtx_ptr_step (
  // operands
  input wire logic [15:0] i_ptr,
  input wire logic i_dec,
  // result
  output logic [15:0] o_ptr
);
  // carry ripples from low byte into high byte
  always_comb begin
    if (i_dec) begin
      o_ptr = i_ptr - `DTX_STEP;
    end else begin
      o_ptr = i_ptr + `DTX_STEP;
    end
  end
endmodule

// >>> dtx_exec_properties.sv
// concurrent checks on the execution unit ports
// assumes a bind onto dtx_exec, one clock domain
`timescale 1ns/1ps
module dtx_exec_properties import dtx_pkg::*; (
  // watched ports
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire instr_t i_instr,
  input wire logic o_busy,
  input wire logic o_done,
  input wire mem_req_t o_dmem,
  input wire logic o_flash_we,
  input wire logic [15:0] o_sp
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);
  logic go;
  logic st2;
  op_t op;
  assign op = i_instr.op;
  assign go = i_start && !o_busy && !o_done;
  assign st2 = op inside {OP_ST_DISP_Y, OP_ST_Z, OP_ST_Z_INC, OP_ST_Z_DEC,
    OP_ST_DIRECT, OP_ST_Y_INC, OP_PUSH};
  // ----
  // timing
  // ----
  a_port_latency:
    assert property (go && op inside {OP_IN, OP_OUT} |-> ##3 o_done)
    else $error("port access latency");
  a_store_latency:
    assert property (go && st2 |-> ##4 o_done)
    else $error("store latency");
  a_rmw_latency:
    assert property (go && op inside {OP_POP, OP_BSET, OP_BCLR}
      |-> ##4 o_done)
    else $error("pop or bit latency");
  a_pload_latency:
    assert property (go && op inside {OP_PLD_R0, OP_PLD, OP_PLD_INC}
      |-> ##5 o_done)
    else $error("program load latency");
  a_pwr_strobe:
    assert property (go && op == OP_PWR |-> ##[1:16] o_flash_we)
    else $error("program write strobe");
  a_done_pulse:
    assert property (o_done |=> !o_done)
    else $error("done not a pulse");
  a_write_pulse:
    assert property (o_dmem.we |=> !o_dmem.we)
    else $error("write strobe not a pulse");
  a_push_sp:
    assert property (go && op == OP_PUSH
      |-> ##5 o_sp == $past(o_sp, 5) - 16'h0001)
    else $error("push stack step");
  a_pop_sp:
    assert property (go && op == OP_POP
      |-> ##5 o_sp == $past(o_sp, 5) + 16'h0001)
    else $error("pop stack step");
  c_pwr: cover property (go && op == OP_PWR);
  c_pop: cover property (go && op == OP_POP);
  c_top: cover property (o_dmem.we && o_dmem.addr == 16'hffff);
endmodule
bind dtx_exec dtx_exec_properties chk (.i_core_clk(i_core_clk),
  .i_nrst(i_nrst), .i_start(i_start), .i_instr(i_instr), .o_busy(o_busy),
  .o_done(o_done), .o_dmem(o_dmem), .o_flash_we(o_flash_we), .o_sp(o_sp));

// >>> dtx_far_side.sv
// data memory, i/o space and flash seen from the unit
// assumes one-cycle read latency and i/o address in addr[5:0]
`timescale 1ns/1ps
module dtx_far_side import dtx_pkg::*; (
  // clock
  input wire logic i_core_clk,
  // requests
  input wire mem_req_t i_dmem,
  input wire mem_req_t i_io,
  input wire logic i_flash_re,
  input wire logic i_flash_we,
  input wire logic [15:0] i_flash_addr,
  input wire logic [15:0] i_flash_wdata,
  // read data
  output logic [7:0] o_dmem_rdata,
  output logic [7:0] o_flash_rdata,
  output logic [7:0] o_io_rdata
);
  logic [7:0] dmem [0:65535];
  logic [7:0] io_mem [0:63];
  logic [15:0] fl_addr;
  logic [15:0] fl_data;
  initial begin
    o_dmem_rdata = 8'h00;
    o_flash_rdata = 8'h00;
    o_io_rdata = 8'h00;
  end
  // idle read lines flip so a stale byte never looks valid
  always @(posedge i_core_clk) begin
    if (i_dmem.we) dmem[i_dmem.addr] <= i_dmem.wdata;
    o_dmem_rdata <= i_dmem.re ? dmem[i_dmem.addr] : ~o_dmem_rdata;
    if (i_io.we) io_mem[i_io.addr[5:0]] <= i_io.wdata;
    o_io_rdata <= i_io.re ? io_mem[i_io.addr[5:0]] : ~o_io_rdata;
    o_flash_rdata <= i_flash_re ?
      i_flash_addr[7:0] + i_flash_addr[15:8] + 8'h11 : ~o_flash_rdata;
    if (i_flash_we) fl_addr <= i_flash_addr;
    if (i_flash_we) fl_data <= i_flash_wdata;
  end
endmodule

// >>> data_transfer_bit_ops_exec_bench.sv
// self-checking bench for the data-transfer execution unit
// assumes dtx_far_side answers memory, i/o and flash reads
`timescale 1ns/1ps
module data_transfer_bit_ops_exec_bench import dtx_pkg::*;;
  logic i_core_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_start = 1'b0;
  instr_t i_instr = '0;
  logic [7:0] dm_rd, fl_rd, io_rd;
  logic busy, done, fl_re, fl_we;
  mem_req_t dm_req, io_req;
  logic [15:0] fl_addr, fl_wd, sp;
  int mismatches = 0;
  int num_checks = 0;
  always #12.5 i_core_clk = ~i_core_clk;
  dtx_exec dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_start(i_start),
    .i_instr(i_instr), .i_dmem_rdata(dm_rd), .i_flash_rdata(fl_rd),
    .i_io_rdata(io_rd), .o_busy(busy), .o_done(done), .o_dmem(dm_req),
    .o_io(io_req), .o_flash_re(fl_re), .o_flash_we(fl_we),
    .o_flash_addr(fl_addr), .o_flash_wdata(fl_wd), .o_sp(sp));
  dtx_far_side far (.i_core_clk(i_core_clk), .i_dmem(dm_req), .i_io(io_req),
    .i_flash_re(fl_re), .i_flash_we(fl_we), .i_flash_addr(fl_addr),
    .i_flash_wdata(fl_wd), .o_dmem_rdata(dm_rd), .o_flash_rdata(fl_rd),
    .o_io_rdata(io_rd));
  // ----
  // helpers
  // ----
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  // a carries bit, displacement and direct address together
  task automatic issue(input op_t op, input logic [4:0] r,
      input logic [5:0] io, input logic [15:0] a);
    int n;
    n = 0;
    @(negedge i_core_clk);
    i_instr = '{op, r, io, a[2:0], a[5:0], a};
    i_start = 1'b1;
    @(negedge i_core_clk);
    i_start = 1'b0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge i_core_clk);
      n++;
    end
    if (n == 20) begin
      mismatches++;
      results();
    end
    // let the strobe issued with done land in the far side
    @(negedge i_core_clk);
  endtask
  task automatic set_reg(input logic [4:0] r, input logic [7:0] v);
    far.io_mem[63] = v;
    issue(OP_IN, r, 6'd63, 16'h0000);
  endtask
  task automatic see(input logic [4:0] r, input logic [7:0] v);
    issue(OP_OUT, r, 6'd62, 16'h0000);
    chk("reg", {8'h00, v}, {8'h00, far.io_mem[62]});
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_z_store();
    set_reg(5'd16, 8'ha5);
    set_reg(5'd17, 8'h3c);
    see(5'd16, 8'ha5);
    set_reg(5'd30, 8'hff);
    set_reg(5'd31, 8'hff);
    issue(OP_ST_Z, 5'd16, 6'd0, 16'h0000);
    chk("z", 16'h00a5, far.dmem[16'hffff]);
    issue(OP_ST_Z_INC, 5'd17, 6'd0, 16'h0000);
    chk("z inc", 16'h003c, far.dmem[16'hffff]);
    issue(OP_ST_Z, 5'd16, 6'd0, 16'h0000);
    chk("z wrap", 16'h00a5, far.dmem[16'h0000]);
    far.dmem[16'hffff] = 8'h00;
    issue(OP_ST_Z_DEC, 5'd17, 6'd0, 16'h0000);
    chk("z dec", 16'h003c, far.dmem[16'hffff]);
    see(5'd31, 8'hff);
  endtask
  task automatic t_y_store();
    set_reg(5'd28, 8'h10);
    set_reg(5'd29, 8'h01);
    issue(OP_ST_DISP_Y, 5'd16, 6'd0, 16'h003f);
    chk("y disp", 16'h00a5, far.dmem[16'h014f]);
    issue(OP_ST_Y_INC, 5'd17, 6'd0, 16'h0000);
    chk("y inc", 16'h003c, far.dmem[16'h0110]);
    issue(OP_ST_DISP_Y, 5'd16, 6'd0, 16'h0000);
    chk("y next", 16'h00a5, far.dmem[16'h0111]);
    issue(OP_ST_DIRECT, 5'd17, 6'd0, 16'h1234);
    chk("direct", 16'h003c, far.dmem[16'h1234]);
  endtask
  task automatic t_flash();
    issue(OP_PLD_R0, 5'd9, 6'd0, 16'h0000);
    see(5'd0, 8'h0f);
    issue(OP_PLD, 5'd18, 6'd0, 16'h0000);
    see(5'd18, 8'h0f);
    issue(OP_PLD_INC, 5'd19, 6'd0, 16'h0000);
    see(5'd19, 8'h0f);
    issue(OP_PLD_INC, 5'd20, 6'd0, 16'h0000);
    see(5'd20, 8'h11);
    set_reg(5'd1, 8'h7e);
    issue(OP_PWR, 5'd0, 6'd0, 16'h0000);
    chk("pwr addr", 16'h0001, far.fl_addr);
    chk("pwr data", 16'h7e0f, far.fl_data);
  endtask
  task automatic t_stack();
    far.dmem[16'h0000] = 8'h00;
    far.dmem[16'hffff] = 8'h00;
    issue(OP_PUSH, 5'd16, 6'd0, 16'h0000);
    chk("push", 16'h00a5, far.dmem[16'h0000]);
    issue(OP_PUSH, 5'd17, 6'd0, 16'h0000);
    chk("push wrap", 16'h003c, far.dmem[16'hffff]);
    issue(OP_POP, 5'd21, 6'd0, 16'h0000);
    issue(OP_POP, 5'd22, 6'd0, 16'h0000);
    see(5'd21, 8'h3c);
    see(5'd22, 8'ha5);
    chk("sp", 16'h0000, sp);
  endtask
  task automatic t_bits();
    logic [7:0] m;
    far.io_mem[9] = 8'h5a;
    for (int b = 0; b < 8; b++) begin
      m = 8'h01 << b;
      issue(OP_BSET, 5'd0, 6'd9, 16'(b));
      chk("set", {8'h00, 8'h5a | m}, {8'h00, far.io_mem[9]});
      issue(OP_BCLR, 5'd0, 6'd9, 16'(b));
      chk("clr", {8'h00, 8'h5a & ~m}, {8'h00, far.io_mem[9]});
      far.io_mem[9] = 8'h5a;
    end
  endtask
  initial begin
    repeat (5) @(negedge i_core_clk);
    i_nrst = 1'b1;
    t_z_store();
    t_y_store();
    t_flash();
    t_stack();
    t_bits();
    results();
  end
endmodule
